// ---- dv/pbbm_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: core bus driver and debug-mode tracker
module pbbm_core_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire pbbm_pkg::pbbm_bus_t cmd,
   input wire logic leave,
   input wire logic debugException,
   output pbbm_pkg::pbbm_bus_t bus,
   output logic debugModeActive
);
   pbbm_pkg::pbbm_bus_t lastReg; // Value shown on the bus last cycle
   ////////////////////////////////////////////////////////////
   // Idle bus flips every cycle, so a stale cycle can never match by luck
   always_comb
   begin
      bus = cmd.valid ? cmd : ~lastReg;
      bus.valid = cmd.valid;
   end
   // Remember what was shown
   always_ff @(posedge core_clk)
   begin
      lastReg <= rst ? '0 : bus;
   end
   // Handler runs from the exception until the bench says it returns
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         debugModeActive <= 1'b0;
      end
      else if (debugException)
      begin
         debugModeActive <= 1'b1;
      end
      else if (leave)
      begin
         debugModeActive <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- dv/processor_bus_break_match_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module processor_bus_break_match_tb;
   localparam logic [31:0] SB = pbbm_pkg::SEG_BASE; // Register window base
   localparam logic [31:0] ST = 32'h4100_0000; // Status with flag clear
   logic core_clk, rst, sel, dm, prc, leave, rdHit, exc, intSet, redir;
   pbbm_pkg::pbbm_bus_t cmd, bus;
   pbbm_pkg::pbbm_reg_req_t req;
   logic [31:0] rdData, baseData;
   logic [35:0] baseAddr;
   int num_errors, samples_checked, seed;
   logic [31:0] readQ [$]; // Expected read words
   logic [2:0] evQ [$]; // Expected {exception, interrupt, redirect}
   pbbm_pkg::pbbm_acc_t kindT [11];
   logic [35:0] axT [11];
   logic [31:0] dxT [11];
   logic [10:0] hitV; // Which table cases break
   ////////////////////////////////////////////////////////////
   pbbm_top u_dut (.core_clk(core_clk), .rst(rst), .bus(bus), .req(req), .debugSegmentSelect(sel),
      .debugModeActive(dm), .processorResetControl(prc), .rdData(rdData), .rdHit(rdHit),
      .debugException(exc), .debugInterruptFlagSet(intSet), .probeRedirect(redir));
   pbbm_core_model u_core (.core_clk(core_clk), .rst(rst), .cmd(cmd), .leave(leave),
      .debugException(exc), .bus(bus), .debugModeActive(dm));
   ////////////////////////////////////////////////////////////
   // Clock, 4 ns period
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Hang guard
   initial
   begin
      #200000;
      num_errors++;
      summarize();
   end
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // Outputs settle long before the falling edge; an empty queue means an unwanted result
   always @(negedge core_clk)
   begin
      if (rdHit !== 1'b0)
      begin
         cmp("rdData", readQ.size() > 0 ? readQ.pop_front() : 32'hxxxx_xxxx, rdData);
      end
      if ({exc, intSet, redir} !== 3'b000)
      begin
         cmp("events", evQ.size() > 0 ? {29'h0, evQ.pop_front()} : 32'hxxxx_xxxx, {29'h0, exc, intSet, redir});
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic regWr(input logic [15:0] ofs, input logic [31:0] d);
      @(posedge core_clk);
      #1;
      req = '{rd: 1'b0, wr: 1'b1, addr: SB | {16'h0000, ofs}, wdata: d};
      @(posedge core_clk);
      #1;
      req.wr = 1'b0;
   endtask
   task automatic regRd(input logic [31:0] a, input logic hit, input logic [31:0] exp);
      if (hit)
      begin
         readQ.push_back(exp);
      end
      @(posedge core_clk);
      #1;
      req.rd = 1'b1;
      req.addr = a;
      @(posedge core_clk);
      #1;
      req.rd = 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic busCyc(input pbbm_pkg::pbbm_acc_t k, input logic [35:0] a, input logic [31:0] d,
      input logic [2:0] ev);
      if (ev != 3'b000)
      begin
         evQ.push_back(ev);
      end
      @(posedge core_clk);
      #1;
      cmd = '{valid: 1'b1, kind: k, addr: a, data: d};
      @(posedge core_clk);
      #1;
      cmd.valid = 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   // Handler returns from debug mode
   task automatic leaveDm();
      @(posedge core_clk);
      #1;
      leave = 1'b1;
      @(posedge core_clk);
      #1;
      leave = 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      seed = 32'h0000_441e;
      {rst, sel, prc, leave} = 4'hC;
      cmd = '0;
      req = '0;
      num_errors = 0;
      samples_checked = 0;
      for (int i = 0; i < 11; i++)
      begin
         kindT[i] = pbbm_pkg::PBBM_ACC_CSTORE;
      end
      kindT[1] = pbbm_pkg::PBBM_ACC_USTORE;
      kindT[2] = pbbm_pkg::PBBM_ACC_ULOAD;
      kindT[3] = pbbm_pkg::PBBM_ACC_OTHER;
      axT = '{'0, '0, '0, '0, 36'h0_0000_0020, 36'h0_0000_0040, '0, '0, 36'h2_0000_0000, 36'h4_0000_0000,
         36'h0_1000_0000};
      dxT = '{'0, '0, '0, '0, '0, '0, 32'h0000_0010, 32'h0000_0100, '0, '0, '0};
      hitV = 11'h155;
      baseAddr = 36'({$random(seed), $random(seed)});
      baseData = $random(seed);
      repeat (10) @(posedge core_clk);
      #1;
      rst = 1'b0;
      regRd(SB | 32'h0000_000C, 1'b1, ST);
      regRd(SB | 32'h0000_030C, 1'b1, 32'h0000_0030);
      regRd(SB | 32'h0000_0100, 1'b1, 32'h0000_0000);
      regRd(32'hFF20_000C, 1'b0, 32'h0000_0000);
      sel = 1'b0;
      regRd(SB | 32'h0000_000C, 1'b0, 32'h0000_0000);
      sel = 1'b1;
      // Break mode: one masked low bit, data mask on bits 7..4, high mask bit 33
      regWr(16'h0300, baseAddr[31:0]);
      regWr(16'h0304, baseData);
      regWr(16'h0308, 32'hFF00_00F0);
      regWr(16'h030C, 32'h0000_2081);
      regWr(16'h0310, {28'h0, baseAddr[35:32]});
      regWr(16'h0314, 32'h0000_0002);
      regRd(SB | 32'h0000_030C, 1'b1, 32'h0000_20B1);
      regRd(SB | 32'h0000_0310, 1'b1, {28'h0, baseAddr[35:32]});
      regRd(SB | 32'h0000_0314, 1'b1, 32'h0000_0002);
      for (int i = 0; i < 11; i++)
      begin
         busCyc(kindT[i], baseAddr ^ axT[i], baseData ^ dxT[i], hitV[i] ? 3'b110 : 3'b000);
         regRd(SB | 32'h0000_000C, 1'b1, ST | {31'h0, hitV[i]});
         regWr(16'h000C, 32'h0000_0000);
         leaveDm();
      end
      // Processor-reset control clears the flag
      busCyc(pbbm_pkg::PBBM_ACC_CSTORE, baseAddr, baseData, 3'b110);
      prc = 1'b1;
      @(negedge core_clk);
      prc = 1'b0;
      regRd(SB | 32'h0000_000C, 1'b1, ST);
      leaveDm();
      // Break inside the handler waits for debug mode to end
      busCyc(pbbm_pkg::PBBM_ACC_CSTORE, baseAddr, baseData, 3'b110);
      busCyc(pbbm_pkg::PBBM_ACC_CSTORE, baseAddr, baseData, 3'b010);
      regWr(16'h000C, 32'h0000_0000);
      evQ.push_back(3'b100);
      leaveDm();
      leaveDm();
      // Overlay mode, break enable cleared, memory addresses only
      regWr(16'h030C, 32'h0000_0088);
      regWr(16'h0308, 32'hFF00_0000);
      busCyc(pbbm_pkg::PBBM_ACC_CSTORE, baseAddr ^ 36'h0_4000_0000, ~baseData, 3'b001);
      busCyc(pbbm_pkg::PBBM_ACC_CSTORE, baseAddr ^ 36'h0_0080_0000, baseData, 3'b000);
      regRd(SB | 32'h0000_000C, 1'b1, ST);
      for (int k = 0; k < 50 && (readQ.size() + evQ.size()) > 0; k++)
      begin
         @(posedge core_clk);
      end
      if ((readQ.size() + evQ.size()) > 0)
      begin
         num_errors++;
         $display("CHECK FAILED pending results exp 0 seen %0d", readQ.size() + evQ.size());
      end
      summarize();
   end
endmodule
`default_nettype wire

// ---- rtl/pbbm_compare.sv ----
`timescale 1ns/1ps
`default_nettype none
// Combinational address/data comparator for one watched bus cycle
module pbbm_compare (
   input wire pbbm_pkg::pbbm_cfg_t cfg,
   input wire pbbm_pkg::pbbm_bus_t bus,
   output logic brkHit,
   output logic ovlHit
);
   logic typeOk;
   logic [35:0] brkAddrMask;
   logic addrBrkOk;
   logic addrOvlOk;
   logic dataOk;

   // Access type gate from the enable bits
   always_comb
   begin
      unique case (bus.kind)
         pbbm_pkg::PBBM_ACC_CSTORE: typeOk = cfg.cstoreEn; // see RL11 see RL23
         pbbm_pkg::PBBM_ACC_USTORE: typeOk = cfg.ustoreEn; // see RL12 see RL23
         pbbm_pkg::PBBM_ACC_ULOAD: typeOk = cfg.uloadEn; // see RL13 see RL23
         default: typeOk = 1'b0;
      endcase
   end

   // Break ignores the upper overlay mask: bits 31..24 always compared
   assign brkAddrMask = {cfg.addrMask[35:32], 8'h00, cfg.addrMask[23:0]}; // see RL17
   assign addrBrkOk = ((bus.addr ^ cfg.addr) & ~brkAddrMask) == 36'h0_0000_0000;
   // Overlay uses all 36 mask bits
   assign addrOvlOk = ((bus.addr ^ cfg.addr) & ~cfg.addrMask) == 36'h0_0000_0000; // see RL14
   assign dataOk = ((bus.data ^ cfg.data) & ~cfg.dataMask) == 32'h0000_0000; // see RL8

   assign brkHit = bus.valid && typeOk && cfg.brkEn && addrBrkOk && dataOk; // see RL17
   assign ovlHit = bus.valid && typeOk && cfg.ovlEn && addrOvlOk; // see RL14
endmodule
`default_nettype wire

// ---- rtl/pbbm_pkg.sv ----
package pbbm_pkg;

   // Register offsets within the debug register segment
   localparam logic [15:0] OFS_STATUS = 16'h000C;
   localparam logic [15:0] OFS_ADDR_LOW = 16'h0300;
   localparam logic [15:0] OFS_DATA_VAL = 16'h0304;
   localparam logic [15:0] OFS_DATA_MASK = 16'h0308;
   localparam logic [15:0] OFS_CTRL = 16'h030C;
   localparam logic [15:0] OFS_ADDR_HIGH = 16'h0310;
   localparam logic [15:0] OFS_HIGH_MASK = 16'h0314;
   // Segment base, upper address bits of the register window
   localparam logic [31:0] SEG_BASE = 32'hFF30_0000;
   localparam logic [31:0] SEG_MASK = 32'hFFF0_0000;

   // Status register field positions and fixed values
   localparam int STAT_OVL_BIT = 30;
   localparam int STAT_CNT_LSB = 24;
   localparam logic [3:0] STAT_CNT_VAL = 4'h1;
   localparam int STAT_BRK_BIT = 0;

   // Control register field positions
   localparam int CTRL_LAM_LSB = 8;
   localparam int CTRL_CSTORE_BIT = 7;
   localparam int CTRL_USTORE_BIT = 6;
   localparam int CTRL_ULOAD_LSB = 4;
   localparam int CTRL_OVL_BIT = 3;
   localparam int CTRL_BRK_BIT = 0;
   // Uncached load and fetch comparison is built in: field reads 11
   localparam logic [1:0] CTRL_ULOAD_VAL = 2'h3;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Access type of the watched bus cycle
   typedef enum logic [1:0] {
      PBBM_ACC_CSTORE,
      PBBM_ACC_USTORE,
      PBBM_ACC_ULOAD,
      PBBM_ACC_OTHER
   } pbbm_acc_t;

   // One observed processor bus cycle
   typedef struct packed {
      logic valid;
      pbbm_acc_t kind;
      logic [35:0] addr;
      logic [31:0] data;
   } pbbm_bus_t;

   // Debug register access port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pbbm_reg_req_t;

   // Match settings handed to the comparator
   typedef struct packed {
      logic [35:0] addr;
      logic [35:0] addrMask;
      logic [31:0] data;
      logic [31:0] dataMask;
      logic cstoreEn;
      logic ustoreEn;
      logic uloadEn;
      logic ovlEn;
      logic brkEn;
   } pbbm_cfg_t;

endpackage

// ---- rtl/pbbm_regfile.sv ----
`timescale 1ns/1ps
`default_nettype none
// Match registers written over the debug register port
module pbbm_regfile (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wrEn,
   input wire logic [15:0] wrOfs,
   input wire logic [31:0] wrData,
   output pbbm_pkg::pbbm_cfg_t cfg,
   output logic [31:0] ctrlWord,
   output logic [31:0] maskWord,
   output logic [3:0] highMask
);
   // All state in one struct
   typedef struct packed {
      logic [31:0] addrLow;
      logic [31:0] dataVal;
      logic [31:0] dataMask;
      logic [23:0] lowMask;
      logic cstoreEn;
      logic ustoreEn;
      logic ovlEn;
      logic brkEn;
      logic [3:0] addrHigh;
      logic [3:0] highMask;
   } pbbm_rf_t;

   pbbm_rf_t st_reg;
   pbbm_rf_t st_next;

   // Register writes; read-only fields ignore the bus
   always_comb
   begin
      st_next = st_reg;
      if (wrEn)
      begin
         unique case (wrOfs)
            pbbm_pkg::OFS_ADDR_LOW: st_next.addrLow = wrData; // see RL6
            pbbm_pkg::OFS_DATA_VAL: st_next.dataVal = wrData; // see RL7
            pbbm_pkg::OFS_DATA_MASK: st_next.dataMask = wrData;
            pbbm_pkg::OFS_CTRL:
            begin
               st_next.lowMask = wrData[31:pbbm_pkg::CTRL_LAM_LSB]; // see RL10
               st_next.cstoreEn = wrData[pbbm_pkg::CTRL_CSTORE_BIT];
               st_next.ustoreEn = wrData[pbbm_pkg::CTRL_USTORE_BIT];
               st_next.ovlEn = wrData[pbbm_pkg::CTRL_OVL_BIT];
               st_next.brkEn = wrData[pbbm_pkg::CTRL_BRK_BIT];
            end
            pbbm_pkg::OFS_ADDR_HIGH: st_next.addrHigh = wrData[3:0]; // see RL21
            pbbm_pkg::OFS_HIGH_MASK: st_next.highMask = wrData[3:0]; // see RL22
            default:
            begin
            end
         endcase
      end
   end

   // Only the enables need a reset; data fields start cleared too
   always_ff @(posedge core_clk)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // Mask register serves as data mask or upper address mask
   always_comb
   begin
      cfg.addr = {st_reg.addrHigh, st_reg.addrLow};
      cfg.addrMask = {st_reg.highMask, st_reg.dataMask[31:24], st_reg.lowMask}; // see RL9
      cfg.data = st_reg.dataVal;
      cfg.dataMask = st_reg.ovlEn ? 32'hFFFF_FFFF : st_reg.dataMask; // see RL8
      cfg.cstoreEn = st_reg.cstoreEn;
      cfg.ustoreEn = st_reg.ustoreEn;
      cfg.uloadEn = &pbbm_pkg::CTRL_ULOAD_VAL; // see RL13
      cfg.ovlEn = st_reg.ovlEn;
      cfg.brkEn = st_reg.brkEn;
   end

   assign ctrlWord = {st_reg.lowMask, st_reg.cstoreEn, st_reg.ustoreEn, pbbm_pkg::CTRL_ULOAD_VAL,
                      st_reg.ovlEn, 2'b00, st_reg.brkEn};
   assign maskWord = st_reg.dataMask;
   assign highMask = st_reg.highMask;
endmodule
`default_nettype wire

// ---- rtl/pbbm_top.sv ----
// Notes on behaviour
// RL1: status overlay-capable bit always reads one
// RL2: channel count reads one, channel bits zero
// RL3: break flag sets on break, resets zero
// RL4: break flag cleared by zero write, resets
// RL5: handler clears break flag before leaving
// RL6: low register holds address bits 31..0
// RL7: data register holds 32-bit compare value
// RL8: mask register masks data without overlay
// RL9: with overlay, mask bits 31..24 mask address
// RL10: control bits 31..8 mask address 23..0
// RL11: control bit 7 enables cached stores
// RL12: control bit 6 enables uncached stores
// RL13: bits 5..4 read 11, uncached loads compared
// RL14: overlay match redirects request to probe
// RL15: software never sets overlay and break together
// RL16: overlay only for memory regions; the code does not check the region and overlays any matching address
// RL17: break match raises debug exception
// RL18: break sets flag and debug interrupt
// RL19: exception held while debug mode active
// RL20: bus break exceptions are imprecise
// RL21: high register bits 3..0 give address 35..32
// RL22: high mask bits 3..0 mask address 35..32
// RL23: disabled access types never match
// RL24: registers live in debug register segment
// RL25: status at 000C, others 0300 to 0314
`timescale 1ns/1ps
`default_nettype none
module pbbm_top (
   input wire logic core_clk,
   input wire logic rst,
   // Watched processor bus cycle
   input wire pbbm_pkg::pbbm_bus_t bus,
   // Debug register access from the core in debug mode
   input wire pbbm_pkg::pbbm_reg_req_t req,
   input wire logic debugSegmentSelect,
   input wire logic debugModeActive,
   input wire logic processorResetControl,
   output logic [31:0] rdData,
   output logic rdHit,
   // Event outputs toward the core and probe
   output logic debugException,
   output logic debugInterruptFlagSet,
   output logic probeRedirect
);
   ////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic brkFlag;
      logic pending;
      logic [31:0] rdData;
      logic rdHit;
      logic excPulse;
      logic intSet;
      logic redirect;
   } pbbm_top_t;

   pbbm_top_t st_reg;
   pbbm_top_t st_next;

   logic segHit;
   logic [15:0] ofs;
   logic wrEn;
   logic brkHit;
   logic ovlHit;
   pbbm_pkg::pbbm_cfg_t cfg;
   logic [31:0] ctrlWord;
   logic [31:0] maskWord;
   logic [3:0] highMask;
   logic [31:0] statusWord;

   ////////////////////////////////////////////////////////////////
   // Decode: only reachable while the segment is selected
   assign segHit = debugSegmentSelect && ((req.addr & pbbm_pkg::SEG_MASK) == pbbm_pkg::SEG_BASE); // see RL24
   assign ofs = req.addr[15:0]; // see RL25
   assign wrEn = req.wr && segHit;

   pbbm_regfile u_regfile (
      .core_clk(core_clk),
      .rst(rst),
      .wrEn(wrEn),
      .wrOfs(ofs),
      .wrData(req.wdata),
      .cfg(cfg),
      .ctrlWord(ctrlWord),
      .maskWord(maskWord),
      .highMask(highMask)
   );

   pbbm_compare u_compare (
      .cfg(cfg),
      .bus(bus),
      .brkHit(brkHit),
      .ovlHit(ovlHit)
   );

   // Status word: fixed capability fields plus the sticky flag
   always_comb
   begin
      statusWord = pbbm_pkg::RST_WORD;
      statusWord[pbbm_pkg::STAT_OVL_BIT] = 1'b1; // see RL1
      statusWord[pbbm_pkg::STAT_CNT_LSB +: 4] = pbbm_pkg::STAT_CNT_VAL; // see RL2
      statusWord[pbbm_pkg::STAT_BRK_BIT] = st_reg.brkFlag; // see RL3
   end

   ////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      st_next = st_reg;
      st_next.excPulse = 1'b0;
      st_next.intSet = 1'b0;
      st_next.rdHit = 1'b0;
      // Redirect follows the matching request one cycle later
      st_next.redirect = ovlHit; // see RL14
      // Clear by zero write or processor reset control; set wins
      if (processorResetControl)
         st_next.brkFlag = 1'b0; // see RL4
      if (wrEn && ofs == pbbm_pkg::OFS_STATUS && !req.wdata[pbbm_pkg::STAT_BRK_BIT])
         st_next.brkFlag = 1'b0; // see RL4
      if (brkHit)
      begin
         st_next.brkFlag = 1'b1; // see RL3 see RL18
         st_next.intSet = 1'b1; // see RL18
         st_next.pending = 1'b1;
      end
      // Exception is imprecise: issued later, deferred in debug mode
      if ((st_reg.pending || brkHit) && !debugModeActive)
      begin
         st_next.excPulse = 1'b1; // see RL19 see RL20
         st_next.pending = 1'b0;
      end
      // Register reads
      if (req.rd && segHit)
      begin
         st_next.rdHit = 1'b1;
         unique case (ofs)
            pbbm_pkg::OFS_STATUS: st_next.rdData = statusWord;
            pbbm_pkg::OFS_ADDR_LOW: st_next.rdData = cfg.addr[31:0];
            pbbm_pkg::OFS_DATA_VAL: st_next.rdData = cfg.data;
            pbbm_pkg::OFS_DATA_MASK: st_next.rdData = maskWord;
            pbbm_pkg::OFS_CTRL: st_next.rdData = ctrlWord;
            pbbm_pkg::OFS_ADDR_HIGH: st_next.rdData = {28'h000_0000, cfg.addr[35:32]};
            pbbm_pkg::OFS_HIGH_MASK: st_next.rdData = {28'h000_0000, highMask};
            default: st_next.rdData = pbbm_pkg::RST_WORD;
         endcase
      end
   end

   // Hard reset clears every flag
   always_ff @(posedge core_clk)
   begin
      if (rst)
         st_reg <= '0; // see RL4
      else
         st_reg <= st_next;
   end

   assign rdData = st_reg.rdData;
   assign rdHit = st_reg.rdHit;
   assign debugException = st_reg.excPulse;
   assign debugInterruptFlagSet = st_reg.intSet;
   assign probeRedirect = st_reg.redirect;

   ////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_hit;
      brkHit && !processorResetControl;
   endsequence

   a_flag_sets: assert property (s_hit |=> st_reg.brkFlag) else $error("flag not set"); // see RL3
   a_int_sets: assert property (brkHit |=> debugInterruptFlagSet) else $error("no debug int"); // see RL18
   a_exc_held: assert property (debugModeActive |=> !debugException) else $error("exc in debug mode"); // see RL19
   a_exc_after: assert property (brkHit && !debugModeActive |=> debugException) else $error("exc lost"); // see RL17
   a_stat_const: assert property (statusWord[31:1] == 31'h2080_0000) else $error("status fixed bad"); // see RL1
   a_zero_clear: assert property (wrEn && ofs == pbbm_pkg::OFS_STATUS && !req.wdata[0] && !brkHit
                                  |=> !st_reg.brkFlag) else $error("clear failed"); // see RL4
   a_ovl_redir: assert property (ovlHit |=> probeRedirect) else $error("no redirect"); // see RL14
   a_no_type: assert property (bus.kind == pbbm_pkg::PBBM_ACC_OTHER |-> !brkHit && !ovlHit)
      else $error("other type matched"); // see RL23

   ////////////////////////////////////////////////////////////////
   // Further checks on the status word, the register port and the match gates.
   // They look at internal hits as well as outputs, so a broken gate shows up
   // whenever a scenario drives the bus into the failing corner, even if no output shows it.

   // Pending break, then debug mode drops: the held exception must follow
   sequence s_held;
      st_reg.pending && debugModeActive;
   endsequence

   sequence s_released;
      s_held ##1 !debugModeActive;
   endsequence

   // A read that is taken by the register port
   sequence s_read_taken;
      req.rd && segHit;
   endsequence

   // Channel count field is a constant one
   a_cnt_field: assert property (statusWord[27:24] == pbbm_pkg::STAT_CNT_VAL) // see RL2
      else $error("channel count bad");

   // Flag bit of the status word mirrors the sticky flag
   a_flag_bit: assert property (statusWord[pbbm_pkg::STAT_BRK_BIT] == st_reg.brkFlag) // see RL3
      else $error("status flag bit bad");

   // Processor-reset control clears the flag unless a break sets it again
   a_prc_clear: assert property (processorResetControl && !brkHit |=> !st_reg.brkFlag) // see RL4
      else $error("reset control clear failed");

   // A new break wins over a zero write in the same cycle
   a_set_wins: assert property (brkHit && wrEn |=> st_reg.brkFlag) // see RL4
      else $error("set lost to clear");

   // Deferred exception comes out one cycle after debug mode ends
   a_exc_release: assert property (s_released |=> debugException) // see RL19
      else $error("held exc not released");

   // No exception without a break now or one still pending
   a_exc_cause: assert property (!brkHit && !st_reg.pending |=> !debugException) // see RL20
      else $error("exc without cause");

   // Interrupt indication only follows a break
   a_int_cause: assert property (!brkHit |=> !debugInterruptFlagSet) // see RL18
      else $error("spurious debug int");

   // Accepted read answers one cycle later
   a_rd_answer: assert property (s_read_taken |=> rdHit) // see RL25
      else $error("read not answered");

   // Reads outside the segment or without select get no answer
   a_rd_refused: assert property (!(req.rd && segHit) |=> !rdHit) // see RL24
      else $error("refused read answered");

   // Uncached load and fetch field always reads 11
   a_fetch_field: assert property (ctrlWord[5:4] == pbbm_pkg::CTRL_ULOAD_VAL) // see RL13
      else $error("fetch field bad");

   // Break needs its enable bit
   a_brk_gate: assert property (!cfg.brkEn |-> !brkHit) // see RL17
      else $error("break while disabled");

   // Overlay needs its enable bit
   a_ovl_gate: assert property (!cfg.ovlEn |-> !ovlHit) // see RL14
      else $error("overlay while disabled");

   // No redirect without an overlay match the cycle before
   a_no_redir: assert property (!ovlHit |=> !probeRedirect) // see RL14
      else $error("spurious redirect");

   // Cached stores only compared when enabled
   a_cstore_gate: assert property (bus.kind == pbbm_pkg::PBBM_ACC_CSTORE && !cfg.cstoreEn |-> !brkHit && !ovlHit) // see RL11
      else $error("cached store matched");

   // Uncached stores only compared when enabled
   a_ustore_gate: assert property (bus.kind == pbbm_pkg::PBBM_ACC_USTORE && !cfg.ustoreEn |-> !brkHit && !ovlHit) // see RL12
      else $error("uncached store matched");

   // An idle bus never matches
   a_idle_bus: assert property (!bus.valid |-> !brkHit && !ovlHit) // see RL23
      else $error("idle bus matched");

   // High address register read shows only bits 35..32
   a_high_read: assert property (s_read_taken && ofs == pbbm_pkg::OFS_ADDR_HIGH |=> rdData[31:4] == 28'h000_0000) // see RL21
      else $error("high address read bad");

   // High mask read shows only its four bits
   a_hmask_read: assert property (s_read_taken && ofs == pbbm_pkg::OFS_HIGH_MASK |=> rdData[31:4] == 28'h000_0000) // see RL22
      else $error("high mask read bad");

   // Mask register doubles as upper address mask in overlay mode
   a_upper_mask: assert property (cfg.addrMask[31:24] == maskWord[31:24]) // see RL9
      else $error("upper mask not routed");
endmodule
`default_nettype wire
